// ### design/unm_pkg.sv
// Shared constants for the nine-bit multiprocessor serial port
package unm_pkg;
  // Special function register addresses
  localparam logic [7:0] CTRL_ADDR  = 8'h98;
  localparam logic [7:0] DATA_ADDR  = 8'h99;
  // Control register reset image: only the unused bit reads high
  localparam logic [7:0] CTRL_RESET = 8'h40;
  localparam logic [7:0] DATA_RESET = 8'h00;
  localparam logic [7:0] READ_NONE  = 8'h00;
  // Control register field positions
  localparam int MODE_BIT   = 7;
  localparam int UNUSED_BIT = 6;
  localparam int MCE_BIT    = 5;
  localparam int REN_BIT    = 4;
  localparam int TB8_BIT    = 3;
  localparam int RB8_BIT    = 2;
  localparam int TI_BIT     = 1;
  localparam int RI_BIT     = 0;
  // Character layout
  localparam int          DATA_BITS = 8;
  localparam logic [2:0]  LAST_BIT  = 3'h7;
  localparam logic        LINE_IDLE = 1'b1;
  // Serial engine states
  typedef enum logic [2:0] {
    TX_IDLE, TX_START, TX_DATA, TX_NINE, TX_STOP
  } unm_tx_e;
  typedef enum logic [2:0] {
    RX_IDLE, RX_START, RX_DATA, RX_NINE, RX_STOP
  } unm_rx_e;
endpackage

// ### design/unm_sync.sv
`timescale 1ns/1ps
`default_nettype none
// Three-stage synchroniser; the level moves only when stages two and
// three agree, which also rejects a single-cycle glitch on the pin.
module unm_sync (
  input  wire logic clk_i,
  input  wire logic reset_i,
  input  wire logic pin_i,
  output logic      level_o
);
  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic lvl;
  } unm_sync_s;

  unm_sync_s s_r;
  unm_sync_s s_nxt;

  // Stage one feeds stage two only
  always_comb begin
    s_nxt     = s_r;
    s_nxt.s1  = pin_i;
    s_nxt.s2  = s_r.s1;
    s_nxt.s3  = s_r.s2;
    if (s_r.s2 == s_r.s3) begin
      s_nxt.lvl = s_r.s3;
    end
  end

  // Idle line is high, so reset to high
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      s_r <= '{s1: 1'b1, s2: 1'b1, s3: 1'b1, lvl: 1'b1};
    end else begin
      s_r <= s_nxt;
    end
  end

  assign level_o = s_r.lvl;
endmodule // unm_sync
`default_nettype wire

// ### design/unm_fifo.sv
`timescale 1ns/1ps
`default_nettype none
// Small flip-flop buffer with valid/ready on both sides
module unm_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 2
) (
  input  wire logic             clk_i,
  input  wire logic             reset_i,
  input  wire logic             in_valid_i,
  input  wire logic [WIDTH-1:0] in_data_i,
  output logic                  in_ready_o,
  output logic                  out_valid_o,
  output logic [WIDTH-1:0]      out_data_o,
  input  wire logic             out_ready_i
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  // Pointers wrap naturally, so depth must be a power of two
  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || WIDTH < 1) begin : g_bad_cfg
    $error("unm_fifo: DEPTH must be a power of two >= 2");
  end

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0]               wp;
    logic [AW-1:0]               rp;
    logic [AW:0]                 cnt;
    logic                        rdy;
  } unm_fifo_s;

  unm_fifo_s s_r;
  unm_fifo_s s_nxt;
  logic      push;
  logic      pop;

  // Ready is kept as a flop so the port does not ripple
  always_comb begin
    s_nxt = s_r;
    push  = in_valid_i && s_r.rdy;
    pop   = out_ready_i && (s_r.cnt != '0);
    if (push) begin
      s_nxt.mem[s_r.wp] = in_data_i;
      s_nxt.wp          = s_r.wp + 1'b1;
    end
    if (pop) begin
      s_nxt.rp = s_r.rp + 1'b1;
    end
    s_nxt.cnt = s_r.cnt + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    s_nxt.rdy = (s_nxt.cnt != (AW+1)'(DEPTH));
  end

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      s_r     <= '0;
      s_r.rdy <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign in_ready_o  = s_r.rdy;
  assign out_valid_o = (s_r.cnt != '0);
  assign out_data_o  = s_r.mem[s_r.rp];
endmodule // unm_fifo
`default_nettype wire

// ### design/unm_uart.sv
`timescale 1ns/1ps
`default_nettype none
module unm_uart #(
  parameter int TX_DEPTH = 2
) (
  input  wire logic       clk_i,
  input  wire logic       reset_i,
  input  wire logic [7:0] sfr_addr_i,
  input  wire logic       sfr_wr_i,
  input  wire logic [7:0] sfr_wdata_i,
  input  wire logic       sfr_bit_wr_i,
  input  wire logic [2:0] sfr_bit_sel_i,
  input  wire logic       sfr_bit_val_i,
  output logic [7:0]      sfr_rdata_o,
  input  wire logic       tx_tick_i,
  input  wire logic       rx_tick_i,
  output logic            rx_timer_reload_o,
  input  wire logic       irq_enable_i,
  output logic            irq_o,
  output logic            tx_buf_ready_o,
  input  wire logic       rxd_i,
  output logic            txd_o
);
  typedef struct packed {
    logic              mode;
    logic              mce;
    logic              ren;
    logic              tb8;
    logic              rb8;
    logic              ti;
    logic              ri;
    logic [7:0]        rxbuf;
    unm_pkg::unm_tx_e  tx_st;
    logic              tx_div;
    logic [7:0]        tx_sh;
    logic [2:0]        tx_cnt;
    logic              txd;
    unm_pkg::unm_rx_e  rx_st;
    logic              rx_half;
    logic [7:0]        rx_sh;
    logic [2:0]        rx_cnt;
    logic              rx_nine;
    logic              rx_prev;
    logic              reload;
    logic              irq;
    logic [7:0]        rdata;
  } unm_uart_s;

  unm_uart_s  s_r;
  unm_uart_s  s_nxt;
  logic       rxd;
  logic       fifo_valid;
  logic [7:0] fifo_data;
  logic       fifo_pop;
  logic       data_wr;
  logic       tx_bd;
  logic       rx_bd;
  logic       start_det;
  logic       ti_set;
  logic       ri_set;
  logic       rx_load;
  logic       stop_ok;
  logic       ctrl_wr;
  logic [7:0] wimg;

  // Control register image as software sees it
  function automatic logic [7:0] ctrl_image(input unm_uart_s s);
    logic [7:0] v;
    v                      = 8'h00;
    v[unm_pkg::MODE_BIT]   = s.mode;
    v[unm_pkg::UNUSED_BIT] = 1'b1;
    v[unm_pkg::MCE_BIT]    = s.mce;
    v[unm_pkg::REN_BIT]    = s.ren;
    v[unm_pkg::TB8_BIT]    = s.tb8;
    v[unm_pkg::RB8_BIT]    = s.rb8;
    v[unm_pkg::TI_BIT]     = s.ti;
    v[unm_pkg::RI_BIT]     = s.ri;
    return v;
  endfunction
  unm_sync u_sync (
    .clk_i   (clk_i),
    .reset_i (reset_i),
    .pin_i   (rxd_i),
    .level_o (rxd)
  );
  // Written bytes queue here so a busy shifter does not lose them
  unm_fifo #(.WIDTH(unm_pkg::DATA_BITS), .DEPTH(TX_DEPTH)) u_fifo (
    .clk_i       (clk_i),
    .reset_i     (reset_i),
    .in_valid_i  (data_wr),
    .in_data_i   (sfr_wdata_i),
    .in_ready_o  (tx_buf_ready_o),
    .out_valid_o (fifo_valid),
    .out_data_o  (fifo_data),
    .out_ready_i (fifo_pop)
  );

  assign data_wr = sfr_wr_i && (sfr_addr_i == unm_pkg::DATA_ADDR);
  // Whole-byte or single-bit write image for the control register
  always_comb begin
    ctrl_wr = (sfr_wr_i || sfr_bit_wr_i) &&
              (sfr_addr_i == unm_pkg::CTRL_ADDR);
    wimg    = ctrl_image(s_r);
    if (sfr_wr_i) begin
      wimg = sfr_wdata_i;
    end else begin
      wimg[sfr_bit_sel_i] = sfr_bit_val_i;
    end
  end

  // Entire next-state: transmitter, receiver and register file
  always_comb begin
    s_nxt        = s_r;
    s_nxt.reload = 1'b0;
    fifo_pop     = 1'b0;
    ti_set       = 1'b0;
    ri_set       = 1'b0;
    rx_load      = 1'b0;
    stop_ok      = 1'b0;
    // Overflow over two gives one bit time
    tx_bd = tx_tick_i && s_r.tx_div;
    if (tx_tick_i) begin
      s_nxt.tx_div = ~s_r.tx_div;
    end
    unique case (s_r.tx_st)
      unm_pkg::TX_IDLE: if (tx_bd && fifo_valid) begin
        fifo_pop    = 1'b1;
        s_nxt.tx_sh = fifo_data;
        s_nxt.txd   = 1'b0;
        s_nxt.tx_st = unm_pkg::TX_START;
      end
      unm_pkg::TX_START: if (tx_bd) begin
        s_nxt.txd    = s_r.tx_sh[0];
        s_nxt.tx_cnt = 3'h0;
        s_nxt.tx_st  = unm_pkg::TX_DATA;
      end
      unm_pkg::TX_DATA: if (tx_bd) begin
        if (s_r.tx_cnt == unm_pkg::LAST_BIT) begin
          if (s_r.mode) begin
            s_nxt.txd   = s_r.tb8;
            s_nxt.tx_st = unm_pkg::TX_NINE;
          end else begin
            s_nxt.txd   = unm_pkg::LINE_IDLE;
            s_nxt.tx_st = unm_pkg::TX_STOP;
            ti_set      = 1'b1;
          end
        end else begin
          s_nxt.tx_sh  = {1'b0, s_r.tx_sh[7:1]};
          s_nxt.txd    = s_r.tx_sh[1];
          s_nxt.tx_cnt = s_r.tx_cnt + 3'h1;
        end
      end
      unm_pkg::TX_NINE: if (tx_bd) begin
        s_nxt.txd   = unm_pkg::LINE_IDLE;
        s_nxt.tx_st = unm_pkg::TX_STOP;
        ti_set      = 1'b1;
      end
      unm_pkg::TX_STOP: if (tx_bd) begin
        s_nxt.tx_st = unm_pkg::TX_IDLE;
      end
      default: s_nxt.tx_st = unm_pkg::TX_IDLE;
    endcase

    // Receiver: reload at the start edge puts later ticks mid-bit
    s_nxt.rx_prev = rxd;
    start_det = s_r.ren && (s_r.rx_st == unm_pkg::RX_IDLE) &&
                s_r.rx_prev && !rxd;
    rx_bd = rx_tick_i && s_r.rx_half;
    if (rx_tick_i) begin
      s_nxt.rx_half = ~s_r.rx_half;
    end
    if (!s_r.ren) begin
      s_nxt.rx_st = unm_pkg::RX_IDLE;
    end else begin
      unique case (s_r.rx_st)
        unm_pkg::RX_IDLE: if (start_det) begin
          s_nxt.reload  = 1'b1;
          s_nxt.rx_half = 1'b1;
          s_nxt.rx_st   = unm_pkg::RX_START;
        end
        unm_pkg::RX_START: if (rx_bd) begin
          // A start that is high again at mid-bit was noise
          s_nxt.rx_st  = rxd ? unm_pkg::RX_IDLE : unm_pkg::RX_DATA;
          s_nxt.rx_cnt = 3'h0;
        end
        unm_pkg::RX_DATA: if (rx_bd) begin
          s_nxt.rx_sh  = {rxd, s_r.rx_sh[7:1]};
          s_nxt.rx_cnt = s_r.rx_cnt + 3'h1;
          if (s_r.rx_cnt == unm_pkg::LAST_BIT) begin
            s_nxt.rx_st = s_r.mode ? unm_pkg::RX_NINE : unm_pkg::RX_STOP;
          end
        end
        unm_pkg::RX_NINE: if (rx_bd) begin
          s_nxt.rx_nine = rxd;
          s_nxt.rx_st   = unm_pkg::RX_STOP;
        end
        unm_pkg::RX_STOP: if (rx_bd) begin
          s_nxt.rx_st = unm_pkg::RX_IDLE;
          stop_ok = s_r.mode ? (!s_r.mce || s_r.rx_nine)
                             : (!s_r.mce || rxd);
          rx_load = !s_r.ri && stop_ok;
        end
        default: s_nxt.rx_st = unm_pkg::RX_IDLE;
      endcase
    end

    // Software writes first, hardware events override them
    if (ctrl_wr) begin
      s_nxt.mode = wimg[unm_pkg::MODE_BIT];
      s_nxt.mce  = wimg[unm_pkg::MCE_BIT];
      s_nxt.ren  = wimg[unm_pkg::REN_BIT];
      s_nxt.tb8  = wimg[unm_pkg::TB8_BIT];
      s_nxt.rb8  = wimg[unm_pkg::RB8_BIT];
      s_nxt.ti   = wimg[unm_pkg::TI_BIT];
      s_nxt.ri   = wimg[unm_pkg::RI_BIT];
    end
    if (rx_load) begin
      s_nxt.rxbuf = s_r.rx_sh;
      s_nxt.rb8   = s_r.mode ? s_r.rx_nine : rxd;
      ri_set      = 1'b1;
    end
    s_nxt.ti  = s_nxt.ti | ti_set;
    s_nxt.ri  = s_nxt.ri | ri_set;
    s_nxt.irq = irq_enable_i && (s_r.ti || s_r.ri);

    // Read data is registered: one cycle after the address
    if (sfr_addr_i == unm_pkg::CTRL_ADDR) begin
      s_nxt.rdata = ctrl_image(s_r);
    end else if (sfr_addr_i == unm_pkg::DATA_ADDR) begin
      s_nxt.rdata = s_r.rxbuf;
    end else begin
      s_nxt.rdata = unm_pkg::READ_NONE;
    end
  end

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      s_r         <= '0;
      s_r.tx_st   <= unm_pkg::TX_IDLE;
      s_r.rx_st   <= unm_pkg::RX_IDLE;
      s_r.txd     <= unm_pkg::LINE_IDLE;
      s_r.rx_prev <= unm_pkg::LINE_IDLE;
      s_r.rxbuf   <= unm_pkg::DATA_RESET;
      s_r.rdata   <= unm_pkg::READ_NONE;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign sfr_rdata_o       = s_r.rdata;
  assign txd_o             = s_r.txd;
  assign irq_o             = s_r.irq;
  assign rx_timer_reload_o = s_r.reload;

  property p_bit6_reads_one;
    @(posedge clk_i) disable iff (reset_i)
    sfr_addr_i == unm_pkg::CTRL_ADDR |=> sfr_rdata_o[unm_pkg::UNUSED_BIT];
  endproperty
  a_bit6_reads_one: assert property (p_bit6_reads_one)
    else $error("control bit six did not read one");
  property p_start_low;
    @(posedge clk_i) disable iff (reset_i)
    s_r.tx_st == unm_pkg::TX_START |-> !txd_o;
  endproperty
  a_start_low: assert property (p_start_low)
    else $error("start bit not low");
  property p_ninth_is_tb8;
    @(posedge clk_i) disable iff (reset_i)
    $rose(s_r.tx_st == unm_pkg::TX_NINE) |-> txd_o == $past(s_r.tb8);
  endproperty
  a_ninth_is_tb8: assert property (p_ninth_is_tb8)
    else $error("ninth bit differs from control field");
  property p_ti_at_stop;
    @(posedge clk_i) disable iff (reset_i)
    $rose(s_r.tx_st == unm_pkg::TX_STOP) |-> s_r.ti && txd_o;
  endproperty
  a_ti_at_stop: assert property (p_ti_at_stop)
    else $error("transmit flag not set at stop bit");
  property p_eight_skips_ninth;
    @(posedge clk_i) disable iff (reset_i)
    !s_r.mode && !ctrl_wr |=> s_r.tx_st != unm_pkg::TX_NINE;
  endproperty
  a_eight_skips_ninth: assert property (p_eight_skips_ninth)
    else $error("ninth bit sent in eight-bit mode");
  property p_ri_sticky;
    @(posedge clk_i) disable iff (reset_i)
    s_r.ri && !ctrl_wr |=> s_r.ri;
  endproperty
  a_ri_sticky: assert property (p_ri_sticky)
    else $error("receive flag cleared without a write");
  property p_ren_off_idle;
    @(posedge clk_i) disable iff (reset_i)
    !s_r.ren |=> s_r.rx_st == unm_pkg::RX_IDLE;
  endproperty
  a_ren_off_idle: assert property (p_ren_off_idle)
    else $error("receiver active while disabled");
  property p_irq;
    @(posedge clk_i) disable iff (reset_i)
    irq_enable_i && (s_r.ti || s_r.ri) |=> irq_o;
  endproperty
  a_irq: assert property (p_irq)
    else $error("interrupt request missing");
  property p_reload;
    @(posedge clk_i) disable iff (reset_i)
    start_det |=> rx_timer_reload_o ##1 !rx_timer_reload_o;
  endproperty
  a_reload: assert property (p_reload)
    else $error("receive timer reload not one pulse");
  property p_blocked_load;
    @(posedge clk_i) disable iff (reset_i)
    s_r.ri && s_r.rx_st == unm_pkg::RX_STOP && rx_bd |=> $stable(s_r.rxbuf);
  endproperty
  a_blocked_load: assert property (p_blocked_load)
    else $error("receive buffer overwritten while flag set");
endmodule // unm_uart
`default_nettype wire

// ### verification/unm_remote.sv
`timescale 1ns/1ps
`default_nettype none
// Remote serial node facing the block: it listens on the block's transmit
// line and can send frames into its receive line. A bit lasts BIT_CYC
// clocks, which the bench keeps equal to two baud-timer overflows.
module unm_remote #(
  parameter int BIT_CYC = 16
) (
  input  wire logic       clk_i,
  input  wire logic       line_i,
  input  wire logic       nine_i,
  output logic            line_o,
  output logic            got_o,
  output logic [8:0]      frame_o
);
  // Line idles high between frames
  initial begin
    line_o = 1'b1;
  end

  // Listener; it samples through the stop bit so that a low ninth bit
  // cannot be mistaken for the next start edge
  initial begin : listen
    logic [9:0] b;
    int         i;
    b       = 10'h000;
    got_o   = 1'b0;
    frame_o = 9'h000;
    forever begin
      @(negedge clk_i);
      got_o = 1'b0;
      if (line_i === 1'b0) begin
        repeat (BIT_CYC / 2) @(negedge clk_i);
        for (i = 0; i < (nine_i ? 10 : 9); i++) begin
          repeat (BIT_CYC) @(negedge clk_i);
          b[i] = line_i;
        end
        frame_o = b[8:0];
        got_o   = 1'b1;
      end
    end
  end

  // Sender; an eight-bit frame carries data then stop only. A master
  // marks address frames with a high ninth bit, data frames low.
  task automatic send(input logic nine, input logic [7:0] d,
                      input logic ninth, input logic stop);
    logic [10:0] f;
    int          i;
    f = nine ? {stop, ninth, d, 1'b0} : {1'b1, stop, d, 1'b0};
    for (i = 0; i < (nine ? 11 : 10); i++) begin
      @(negedge clk_i);
      line_o = f[i];
      repeat (BIT_CYC - 1) @(negedge clk_i);
    end
    @(negedge clk_i);
    line_o = 1'b1;
  endtask
endmodule // unm_remote
`default_nettype wire

// ### verification/unm_uart_tb.sv
`timescale 1ns/1ps
`default_nettype none
module unm_uart_tb;
  logic       clk_i         = 1'b0;
  logic       reset_i       = 1'b1;
  logic [7:0] sfr_addr_i    = 8'h00;
  logic       sfr_wr_i      = 1'b0;
  logic [7:0] sfr_wdata_i   = 8'h00;
  logic       sfr_bit_wr_i  = 1'b0;
  logic [2:0] sfr_bit_sel_i = 3'h0;
  logic       sfr_bit_val_i = 1'b0;
  logic       tx_tick_i     = 1'b0;
  logic       rx_tick_i     = 1'b0;
  logic       irq_enable_i  = 1'b1;
  logic       nine          = 1'b1;
  logic       rd_chk        = 1'b0;
  logic       rd_fire       = 1'b0;
  logic [2:0] tx_cnt        = 3'h0;
  logic [2:0] rx_cnt        = 3'h0;
  logic [7:0] sfr_rdata_o;
  logic       rx_timer_reload_o;
  logic       irq_o;
  logic       tx_buf_ready_o;
  logic       rxd_i;
  logic       txd_o;
  logic       got;
  logic [8:0] frame;
  logic [7:0] rq[$];
  logic [8:0] tq[$];
  int         num_errors    = 0;
  int         check_count   = 0;
  int         seed          = 32'hF649D964;
  // Receive cases: control image written, then {ninth, stop} sent
  logic [7:0] rows [8] = '{8'h80, 8'h90, 8'h91, 8'hB0,
                           8'hB0, 8'h30, 8'h30, 8'h14};
  logic [1:0] bits [8] = '{2'h3, 2'h0, 2'h3, 2'h1,
                           2'h3, 2'h0, 2'h1, 2'h2};

  always #12.5 clk_i = ~clk_i;

  unm_uart u_dut (
    .clk_i(clk_i), .reset_i(reset_i), .sfr_addr_i(sfr_addr_i),
    .sfr_wr_i(sfr_wr_i), .sfr_wdata_i(sfr_wdata_i),
    .sfr_bit_wr_i(sfr_bit_wr_i), .sfr_bit_sel_i(sfr_bit_sel_i),
    .sfr_bit_val_i(sfr_bit_val_i), .sfr_rdata_o(sfr_rdata_o),
    .tx_tick_i(tx_tick_i), .rx_tick_i(rx_tick_i),
    .rx_timer_reload_o(rx_timer_reload_o), .irq_enable_i(irq_enable_i),
    .irq_o(irq_o), .tx_buf_ready_o(tx_buf_ready_o), .rxd_i(rxd_i),
    .txd_o(txd_o)
  );

  unm_remote u_remote (
    .clk_i(clk_i), .line_i(txd_o), .nine_i(nine), .line_o(rxd_i),
    .got_o(got), .frame_o(frame)
  );

  // Baud timers overflow every eight clocks; the receive copy restarts
  // on the reload pulse, otherwise sampling would drift off mid-bit
  always @(negedge clk_i) begin
    tx_cnt    = tx_cnt + 3'h1;
    rx_cnt    = rx_timer_reload_o ? 3'h0 : rx_cnt + 3'h1;
    tx_tick_i = (tx_cnt == 3'h7);
    rx_tick_i = (rx_cnt == 3'h7);
  end

  task automatic cmp_reg(input logic [7:0] g, input logic [7:0] e);
    check_count++;
    if (g !== e) begin
      num_errors++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  task automatic cmp_frame(input logic [8:0] g, input logic [8:0] e);
    check_count++;
    if (g !== e) begin
      num_errors++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  // Watchers: read data lands one cycle after the address is shown
  always @(posedge clk_i) rd_fire <= rd_chk;
  always @(negedge clk_i) begin
    if (rd_fire) cmp_reg(sfr_rdata_o, rq.pop_front());
  end
  always @(posedge clk_i) begin
    if (got) cmp_frame(frame, tq.pop_front());
  end

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_i);
    sfr_addr_i  = a;
    sfr_wdata_i = d;
    sfr_wr_i    = 1'b1;
    @(negedge clk_i);
    sfr_wr_i    = 1'b0;
  endtask

  task automatic bw(input logic [2:0] s, input logic v);
    @(negedge clk_i);
    sfr_addr_i    = unm_pkg::CTRL_ADDR;
    sfr_bit_sel_i = s;
    sfr_bit_val_i = v;
    sfr_bit_wr_i  = 1'b1;
    @(negedge clk_i);
    sfr_bit_wr_i  = 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(negedge clk_i);
    sfr_addr_i = a;
    rq.push_back(e);
    rd_chk     = 1'b1;
    @(negedge clk_i);
    rd_chk     = 1'b0;
  endtask

  // Waits, bounded, until the remote node has seen every queued frame
  task automatic drain;
    int n;
    n = 0;
    while (tq.size() != 0 && n < 4000) begin
      @(negedge clk_i);
      n++;
    end
    cmp_reg(8'(tq.size()), 8'h00);
    repeat (4) @(negedge clk_i);
  endtask

  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // Whole run is near 2500 clocks; this cuts a hang short
  initial begin : watchdog
    repeat (30000) @(posedge clk_i);
    num_errors++;
    end_sim();
  end

  initial begin : main
    logic [7:0] c;
    logic [7:0] d;
    logic [7:0] last;
    logic       nb;
    int         i;
    last = unm_pkg::DATA_RESET;
    repeat (6) @(negedge clk_i);
    reset_i = 1'b0;
    // Reset image, decoding, unused bit and single-bit writes
    rd(unm_pkg::CTRL_ADDR, unm_pkg::CTRL_RESET);
    rd(unm_pkg::DATA_ADDR, unm_pkg::DATA_RESET);
    rd(8'h55, unm_pkg::READ_NONE);
    wr(unm_pkg::CTRL_ADDR, 8'h00);
    rd(unm_pkg::CTRL_ADDR, 8'h40);
    bw(3'h7, 1'b1);
    bw(3'h3, 1'b1);
    bw(3'h6, 1'b0);
    rd(unm_pkg::CTRL_ADDR, 8'hC8);
    $display("test registers done");
    // Burst of writes; a byte offered while the buffer is full is lost
    @(negedge clk_i);
    sfr_addr_i = unm_pkg::DATA_ADDR;
    sfr_wr_i   = 1'b1;
    for (i = 0; i < 4; i++) begin
      d           = 8'($random(seed));
      sfr_wdata_i = d;
      // An empty two-entry buffer must take the first two bytes
      if (i < 2) cmp_reg({7'h00, tx_buf_ready_o}, 8'h01);
      if (tx_buf_ready_o === 1'b1) tq.push_back({1'b1, d});
      @(negedge clk_i);
    end
    sfr_wr_i = 1'b0;
    drain();
    rd(unm_pkg::CTRL_ADDR, 8'hCA);
    cmp_reg({7'h00, irq_o}, 8'h01);
    // Ninth bit low, then eight-bit mode where the stop bit follows data
    wr(unm_pkg::CTRL_ADDR, 8'h80);
    d = 8'($random(seed));
    tq.push_back({1'b0, d});
    wr(unm_pkg::DATA_ADDR, d);
    drain();
    rd(unm_pkg::CTRL_ADDR, 8'hC2);
    nine = 1'b0;
    // Ninth-transmit field set high must not reach the line here
    wr(unm_pkg::CTRL_ADDR, 8'h08);
    d = 8'($random(seed));
    tq.push_back({1'b1, d});
    wr(unm_pkg::DATA_ADDR, d);
    drain();
    rd(unm_pkg::CTRL_ADDR, 8'h4A);
    irq_enable_i = 1'b0;
    repeat (2) @(negedge clk_i);
    cmp_reg({7'h00, irq_o}, 8'h00);
    irq_enable_i = 1'b1;
    $display("test transmit done");
    // Receive cases: enable off, flag busy, filter pass and fail
    for (i = 0; i < 8; i++) begin
      c  = rows[i];
      nb = c[7];
      d  = 8'($random(seed));
      wr(unm_pkg::CTRL_ADDR, c);
      u_remote.send(nb, d, bits[i][1], bits[i][0]);
      repeat (8) @(negedge clk_i);
      if (c[4] && !c[0] && (!c[5] || (nb ? bits[i][1] : bits[i][0]))) begin
        last = d;
        c[0] = 1'b1;
        c[2] = nb ? bits[i][1] : bits[i][0];
      end
      rd(unm_pkg::CTRL_ADDR, c | 8'h40);
      rd(unm_pkg::DATA_ADDR, last);
      cmp_reg({7'h00, irq_o}, {7'h00, c[0]});
    end
    $display("test receive done");
    end_sim();
  end
endmodule // unm_uart_tb
`default_nettype wire
